// ==== design/sdoc_decimator.sv ====
/*
 * Eight-channel sinc3 + sinc1 decimator with settling suppression and
 * output coding. Assumes one-bit modulator streams valid on each
 * sample_en pulse and a configuration bus held stable by the controller.
 */
module sdoc_decimator
	import sdoc_pkg::*;
#(
	parameter int CHANNELS = NUM_CH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sample_en,
	input wire logic [CHANNELS-1:0] mod_bit,
	input wire sdoc_cfg_t cfg,
	output logic [CHANNELS-1:0][1:0] dither_level,
	output logic output_rate_clock,
	output logic data_ready,
	output logic settled,
	output logic [CHANNELS-1:0][OUT_W-1:0] result
);
	sdoc_cfg_t cfg_q;
	sdoc_phase_t phase;
	logic [8:0] samp_cnt;
	logic [2:0] avg_cnt;
	logic [3:0] settle_cnt;
	logic emit_pend;
	logic ready_pend;
	logic restart;
	logic [3:0] k3;
	logic [3:0] k1;
	logic [4:0] res;
	logic [8:0] third_order_ratio_last;
	logic [2:0] first_order_ratio_last;
	logic [3:0] first_order_ratio;
	logic [3:0] settle_need;
	logic [2:0] avg_start;
	logic dec;
	logic emit_next;
	logic ready_ok;
	logic [5:0] rshift;
	logic [23:0] res_mask;

	// any ratio change restarts settling; width and dither apply at once
	assign restart = cfg.osr != cfg_q.osr;
	assign k3 = sdoc_k3(cfg_q.osr);
	assign k1 = sdoc_k1(cfg_q.osr);
	assign res = sdoc_res(cfg_q.osr);
	assign third_order_ratio_last = 9'((10'h1 << k3) - 10'h1);
	assign first_order_ratio = 4'(5'h1 << k1);
	assign first_order_ratio_last = 3'(first_order_ratio - 4'h1);
	// settling in sinc3 outputs: 3 + first_order_ratio - 1 of them, each third_order_ratio samples long
	assign settle_need = first_order_ratio + SINC3_ORDER - 4'h1;
	// preload so the first average ends exactly on the settling output
	assign avg_start = 3'(3'h0 - 3'h2) & 3'(sdoc_k1(cfg.osr) == 4'h0 ? 3'h0 : (3'h1 << sdoc_k1(cfg.osr)) - 3'h1);
	assign dec = sample_en & (samp_cnt == third_order_ratio_last);
	assign emit_next = dec & (avg_cnt == first_order_ratio_last);
	assign ready_ok = (phase == PH_RUN) | (settle_cnt == settle_need - 4'h1);
	// gain of sinc3 is third_order_ratio^3, sinc1 sum is first_order_ratio: normalise to 2^23
	assign rshift = 6'({2'h0, k3} * 6'h3) + 6'({2'h0, k1}) - SHIFT_BIAS;
	assign res_mask = 24'hFFFFFF << (FULL_RES - res);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= '{osr: OSR_RESET, width: WIDTH_RESET, dither: DITHER_RESET};
		end else begin
			cfg_q <= cfg;
		end
	end

	// dither setting fanned out to every modulator
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dither_level <= '0;
		end else begin
			dither_level <= {CHANNELS{cfg_q.dither}};
		end
	end

	// modulator sample divider down to the sinc3 rate
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_cnt <= '0;
		end else if (restart) begin
			samp_cnt <= '0;
		end else if (sample_en) begin
			samp_cnt <= (samp_cnt == third_order_ratio_last) ? 9'h0 : samp_cnt + 9'h1;
		end
	end

	// sinc3 output divider down to the output rate
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avg_cnt <= '0;
		end else if (restart) begin
			avg_cnt <= avg_start;
		end else if (dec) begin
			avg_cnt <= (avg_cnt == first_order_ratio_last) ? 3'h0 : avg_cnt + 3'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= PH_FILL;
			settle_cnt <= '0;
		end else if (restart) begin
			phase <= PH_FILL;
			settle_cnt <= '0;
		end else if (dec) begin
			case (phase)
				PH_FILL: begin
					settle_cnt <= settle_cnt + 4'h1;
					if (settle_cnt == settle_need - 4'h1) begin
						phase <= PH_RUN;
					end
				end
				PH_RUN: begin
					settle_cnt <= settle_cnt;
				end
				default: begin
					phase <= PH_FILL;
				end
			endcase
		end
	end

	// one cycle after the last comb update the history is complete
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			emit_pend <= 1'b0;
			ready_pend <= 1'b0;
		end else begin
			emit_pend <= emit_next & ~restart;
			ready_pend <= emit_next & ready_ok & ~restart;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			output_rate_clock <= 1'b0;
			data_ready <= 1'b0;
			settled <= 1'b0;
		end else begin
			output_rate_clock <= emit_pend;
			data_ready <= ready_pend;
			settled <= (phase == PH_RUN) & ~restart;
		end
	end

	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
		logic signed [INT_W-1:0] in_val;
		logic signed [INT_W-1:0] int1;
		logic signed [INT_W-1:0] int2;
		logic signed [INT_W-1:0] int3;
		logic signed [INT_W-1:0] int3_next;
		logic signed [INT_W-1:0] dly1;
		logic signed [INT_W-1:0] dly2;
		logic signed [INT_W-1:0] dly3;
		logic signed [INT_W-1:0] comb1;
		logic signed [INT_W-1:0] comb2;
		logic signed [INT_W-1:0] comb3;
		logic signed [INT_W-1:0] hist [HIST_D];
		logic signed [SUM_W-1:0] avg_sum;
		logic signed [WIDE_W-1:0] wide;
		logic [23:0] coded;
		logic [OUT_W-1:0] word;

		assign in_val = mod_bit[ch] ? INT_W'(1) : -INT_W'(1);
		// comb taps the sum this sample makes, else the first settled window misses one input
		assign int3_next = int3 + int2;
		// wraparound integrators are harmless: the combs undo the overflow
		assign comb1 = int3_next - dly1;
		assign comb2 = comb1 - dly2;
		assign comb3 = comb2 - dly3;

		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				int1 <= '0;
				int2 <= '0;
				int3 <= '0;
			end else if (sample_en) begin
				int1 <= int1 + in_val;
				int2 <= int2 + int1;
				int3 <= int3 + int2;
			end
		end

		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				dly1 <= '0;
				dly2 <= '0;
				dly3 <= '0;
				for (int j = 0; j < HIST_D; j++) begin
					hist[j] <= '0;
				end
			end else if (dec) begin
				dly1 <= int3_next;
				dly2 <= comb1;
				dly3 <= comb2;
				hist[0] <= comb3;
				for (int j = 1; j < HIST_D; j++) begin
					hist[j] <= hist[j-1];
				end
			end
		end

		// moving average over the last first_order_ratio sinc3 outputs
		always_comb begin
			avg_sum = '0;
			for (int j = 0; j < HIST_D; j++) begin
				if (4'(j) < first_order_ratio) begin
					avg_sum = avg_sum + SUM_W'(hist[j]);
				end
			end
		end

		always_comb begin
			wide = (WIDE_W'(avg_sum) <<< PRE_SHIFT) >>> rshift;
			if (wide > LIM_POS) begin
				coded = SAT_POS & res_mask;
			end else if (wide < LIM_NEG) begin
				coded = SAT_NEG;
			end else begin
				coded = wide[23:0] & res_mask;
			end
		end

		always_comb begin
			case (cfg_q.width)
				WIDTH_16: word = {16'h0000, coded[23:8]};
				WIDTH_24: word = {8'h00, coded};
				WIDTH_32Z: word = {coded, 8'h00};
				WIDTH_32S: word = {{8{coded[23]}}, coded};
				default: word = {8'h00, coded};
			endcase
		end

		// word held until the next settled result
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				result[ch] <= '0;
			end else if (ready_pend) begin
				result[ch] <= word;
			end
		end
	end
endmodule : sdoc_decimator

// ==== design/sdoc_pkg.sv ====
/*
 * Constants, lookup functions and carrier types for the sinc decimator and
 * output coder. Assumes a single 40 MHz system clock and a one-cycle
 * modulator sample enable supplied from outside.
 */
// Notes on behaviour
// - a two-bit dither level is passed on to every channel's modulator
// - each channel: third-order sinc by first ratio, then first-order moving average
// - settling equals (3 + first_order_ratio - 1) times third_order_ratio samples
// - the averaging stage is used only above total ratio 512, else ratio one
// - codes 000-100 give ratios 32..512; 101-111 add averaging of 2, 4, 8
// - resolution 17, 20, 23 bits at 32, 64, 128; 24 bits from 256 upward
// - results produced before settling are dropped; every ready marks settled data
// - first result after full settling, then one ready per output period
// - stream latency equals the settling time of the selected setting
// - results are 24-bit two's complement words, most significant bit first
// - two-bit width field reformats to 16, 24 or 32 bits; 01 is plain 24
// - positive over-range holds 7FFFFF masked to the resolution, negative over-range holds 800000
// - below 24 bits the result is left justified with zero low bits
// - all channels share one resolution from the common oversampling setting
// - 23-bit codes step by two; full scale 7FFFFE and 800000
// - 20-bit codes step by sixteen; full scale 7FFFF0, minus one FFFFF0
// - 17-bit codes step by 80 hex; full scale 7FFF80, minus one FFFF80
package sdoc_pkg;
	localparam int NUM_CH = 8;
	localparam int INT_W = 29;
	localparam int SUM_W = 32;
	localparam int HIST_D = 8;
	localparam int PRE_SHIFT = 8;
	localparam int WIDE_W = SUM_W + PRE_SHIFT;
	localparam int OUT_W = 32;
	localparam logic [5:0] SHIFT_BIAS = 6'hF;
	localparam logic [3:0] SINC3_ORDER = 4'h3;
	localparam logic [4:0] FULL_RES = 5'h18;
	localparam logic [23:0] SAT_POS = 24'h7FFFFF;
	localparam logic [23:0] SAT_NEG = 24'h800000;
	localparam logic signed [WIDE_W-1:0] LIM_POS = 40'sh00007FFFFF;
	localparam logic signed [WIDE_W-1:0] LIM_NEG = -40'sh0000800000;
	localparam logic [2:0] OSR_RESET = 3'h3;
	localparam logic [1:0] WIDTH_16 = 2'h0;
	localparam logic [1:0] WIDTH_24 = 2'h1;
	localparam logic [1:0] WIDTH_32Z = 2'h2;
	localparam logic [1:0] WIDTH_32S = 2'h3;
	localparam logic [1:0] WIDTH_RESET = WIDTH_24;
	localparam logic [1:0] DITHER_RESET = 2'h0;

	typedef struct packed {
		logic [2:0] osr;
		logic [1:0] width;
		logic [1:0] dither;
	} sdoc_cfg_t;

	typedef enum logic {
		PH_FILL = 1'b0,
		PH_RUN = 1'b1
	} sdoc_phase_t;

	// log2 of the third-order ratio
	function automatic logic [3:0] sdoc_k3(input logic [2:0] osr);
		case (osr)
			3'h0: sdoc_k3 = 4'h5;
			3'h1: sdoc_k3 = 4'h6;
			3'h2: sdoc_k3 = 4'h7;
			3'h3: sdoc_k3 = 4'h8;
			default: sdoc_k3 = 4'h9;
		endcase
	endfunction : sdoc_k3

	// log2 of the first-order ratio
	function automatic logic [3:0] sdoc_k1(input logic [2:0] osr);
		case (osr)
			3'h5: sdoc_k1 = 4'h1;
			3'h6: sdoc_k1 = 4'h2;
			3'h7: sdoc_k1 = 4'h3;
			default: sdoc_k1 = 4'h0;
		endcase
	endfunction : sdoc_k1

	function automatic logic [4:0] sdoc_res(input logic [2:0] osr);
		case (osr)
			3'h0: sdoc_res = 5'h11;
			3'h1: sdoc_res = 5'h14;
			3'h2: sdoc_res = 5'h17;
			default: sdoc_res = FULL_RES;
		endcase
	endfunction : sdoc_res
endpackage : sdoc_pkg

// ==== verification/sdoc_decimator_sva.sv ====
/*
 * port checker for the decimator.
 * assumes cfg is held steady while results flow.
 */
module sdoc_decimator_sva
	import sdoc_pkg::*;
#(
	parameter int CHANNELS = NUM_CH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sample_en,
	input wire logic [CHANNELS-1:0] mod_bit,
	input wire sdoc_cfg_t cfg,
	input wire logic [CHANNELS-1:0][1:0] dither_level,
	input wire logic output_rate_clock,
	input wire logic data_ready,
	input wire logic settled,
	input wire logic [CHANNELS-1:0][OUT_W-1:0] result
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence cfg_steady;
		$stable(cfg) [*3];
	endsequence
	sequence word_out;
		data_ready && cfg.width == WIDTH_24;
	endsequence
	ready_on_rate_a: assert property (data_ready |-> output_rate_clock && settled)
		else $error("ready off rate tick");
	ready_single_a: assert property (data_ready |=> !data_ready)
		else $error("ready too long");
	rate_after_sample_a: assert property (output_rate_clock |-> $past(sample_en, 2))
		else $error("rate tick not after sample");
	rate_gap_a: assert property (output_rate_clock |=> !output_rate_clock [*8])
		else $error("rate ticks too close");
	result_hold_a: assert property (!data_ready |-> $stable(result))
		else $error("result moved without ready");
	first_ready_a: assert property ($rose(settled) |-> data_ready)
		else $error("settled without ready");
	dither_copy_a: assert property (cfg_steady |-> dither_level[0] == cfg.dither &&
		dither_level[CHANNELS-1] == cfg.dither) else $error("dither not passed on");
	left_just_a: assert property (word_out |-> (cfg.osr > 3'h2 || !result[0][0]) &&
		(cfg.osr > 3'h1 || result[0][3:0] == 4'h0) && (cfg.osr != 3'h0 || result[0][6:0] == 7'h00))
		else $error("low bits not zero");
	sign_ext_a: assert property (data_ready && cfg.width == WIDTH_32S |->
		result[0][31:24] == {8{result[0][23]}}) else $error("bad sign extension");
endmodule : sdoc_decimator_sva

bind sdoc_decimator sdoc_decimator_sva #(.CHANNELS(CHANNELS)) u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
	.sample_en(sample_en), .mod_bit(mod_bit), .cfg(cfg), .dither_level(dither_level),
	.output_rate_clock(output_rate_clock), .data_ready(data_ready), .settled(settled), .result(result));

// ==== verification/sdoc_decimator_tb.sv ====
/*
 * self-checking bench: constant full-scale streams per channel.
 * assumes saturation codes are the only expected results.
 */
module sdoc_decimator_tb
	import sdoc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
	logic sys_clk, rst_n, run, sample_en, output_rate_clock, data_ready, settled;
	logic [7:0] pattern, mod_bit;
	sdoc_cfg_t cfg;
	logic [7:0][1:0] dither_level;
	logic [7:0][31:0] result;
	logic [23:0] pos;
	int fails = 0, check_count = 0, cycles = 0, n, last_rate, drc, third_order_ratio, first_order_ratio, settle, total;
	int q[$];
	sdoc_mod_src u_src (.sys_clk(sys_clk), .rst_n(rst_n), .run(run), .pattern(pattern),
		.sample_en(sample_en), .mod_bit(mod_bit));
	sdoc_decimator dut (.sys_clk(sys_clk), .rst_n(rst_n), .sample_en(sample_en), .mod_bit(mod_bit),
		.cfg(cfg), .dither_level(dither_level), .output_rate_clock(output_rate_clock),
		.data_ready(data_ready), .settled(settled), .result(result));
	function automatic logic [31:0] fmt(input logic [23:0] v, input logic [1:0] w);
		case (w)
			2'h0: fmt = {16'h0000, v[23:8]};
			2'h1: fmt = {8'h00, v};
			2'h2: fmt = {v, 8'h00};
			default: fmt = {{8{v[23]}}, v};
		endcase
	endfunction : fmt
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// sampled mid-cycle so counts and outputs have settled
	always @(negedge sys_clk) begin
		cycles++;
		if (output_rate_clock && last_rate != 0) `CHK(n - last_rate, total)
		if (output_rate_clock) last_rate = n;
		if (data_ready) begin
			`CHK(n, q.pop_front())
			`CHK(dither_level[7], cfg.dither)
			for (int c = 0; c < 8; c++)
				`CHK(result[c], fmt(pattern[c] ? pos : SAT_NEG, cfg.width))
			drc++;
		end
		if (sample_en) n++;
		if (cycles == 80000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		rst_n = 1'b0;
		run = 1'b0;
		pattern = 8'h00;
		cfg = {OSR_RESET, WIDTH_RESET, DITHER_RESET};
		void'($urandom(36));
		repeat (5) @(posedge sys_clk);
		for (int o = 0; o < 8; o++) begin
			@(posedge sys_clk);
			rst_n <= 1'b0;
			run <= 1'b0;
			// plain 24-bit words at the three low ratios so the low-bit checker sees every mask
			cfg <= {3'(o), (o < 3) ? 2'h1 : 2'(o), (o > 4) ? 2'h3 : 2'($urandom)};
			pattern <= 8'($urandom);
			third_order_ratio = 32 << ((o > 4) ? 4 : o);
			first_order_ratio = (o > 4) ? 1 << (o - 4) : 1;
			settle = (3 + first_order_ratio - 1) * third_order_ratio;
			total = first_order_ratio * third_order_ratio;
			pos = o == 0 ? 24'h7FFF80 : o == 1 ? 24'h7FFFF0 : o == 2 ? 24'h7FFFFE : SAT_POS;
			q = {settle, settle + total};
			repeat (2) @(posedge sys_clk);
			rst_n <= 1'b1;
			repeat (3) @(posedge sys_clk);
			n = 0;
			last_rate = 0;
			drc = 0;
			run <= 1'b1;
			wait (drc == 2);
			$display("test osr %0d done", o);
		end
		print_verdict();
	end
endmodule : sdoc_decimator_tb

// ==== verification/sdoc_mod_src.sv ====
/*
 * modulator stream source: one sample tick every third cycle.
 * assumes pattern is held while run is high.
 */
module sdoc_mod_src (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [7:0] pattern,
	output logic sample_en,
	output logic [7:0] mod_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt;
	// bits off the tick show the inverse, so nothing leans on a stale value
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 2'h0;
			sample_en <= 1'b0;
			mod_bit <= 8'h00;
		end else begin
			cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
			sample_en <= run && cnt == 2'h2;
			mod_bit <= (run && cnt == 2'h2) ? pattern : ~pattern;
		end
	end
endmodule : sdoc_mod_src
